// file: pkg/rww_map.svh
// Offsets, field positions and timing counts of the reset and watchdog block.
// Assumes a 40 MHz system clock and a 16-bit control word at chip select.
`ifndef RWW_MAP_SVH
`define RWW_MAP_SVH
`define RWW_CLK_MHZ 40
`define RWW_WR_BIT 15
`define RWW_PER_LSB 0
`define RWW_PER_W 3
`define RWW_SHORT_BIT 3
`define RWW_STAY_BIT 4
`define RWW_SW_ONE_BIT 5
`define RWW_SW_TWO_BIT 6
`define RWW_MODE_LSB 7
`define RWW_SUPPLY_OK_BIT 9
`define RWW_FILTER_NS 10000
`define RWW_FILTER_CYC ((`RWW_FILTER_NS * `RWW_CLK_MHZ + 999) / 1000)
`define RWW_LONG_OPEN_MS 64
`define RWW_POR_DELAY_MS 10
`define RWW_SHORT_DELAY_MS 1
`define RWW_HALF_BASE_MS 8
`define RWW_MS_CYC(ms) ((ms) * `RWW_CLK_MHZ * 1000)
`endif

// file: pkg/rww_pkg.sv
// Types shared by the reset and watchdog block.
// Assumes the mode codes match the control word mode field.
package rww_pkg;
	typedef enum logic [1:0] {
		MODE_STANDBY = 2'h0,
		MODE_ACTIVE = 2'h1,
		MODE_STOP = 2'h2,
		MODE_SLEEP = 2'h3
	} mode_t;
	typedef enum logic [1:0] {
		RS_RUN = 2'h0,
		RS_FILTER = 2'h1,
		RS_HOLD = 2'h2,
		RS_DELAY = 2'h3
	} rst_state_t;
	typedef enum logic [2:0] {
		WD_HALT = 3'h0,
		WD_LONG = 3'h1,
		WD_CLOSED = 3'h2,
		WD_OPEN = 3'h3,
		WD_SUSP = 3'h4
	} wd_state_t;
endpackage : rww_pkg

// file: pkg/cycle_timer_if.sv
// Link between the reset and watchdog control and its shared cycle timer.
// Assumes both ends run on the same clock.
`timescale 1ns/100ps
interface cycle_timer_if;
	logic restart;
	logic [31:0] load;
	logic expired;
	modport owner (output restart, output load, input expired);
	modport timer (input restart, input load, output expired);
endinterface : cycle_timer_if

// file: rtl/cycle_timer.sv
// Down counter shared by every window and release delay.
// Assumes the owner restarts it at each boundary it cares about.
`timescale 1ns/100ps
module cycle_timer
(
	input wire logic sys_clk,
	input wire logic nrst,
	cycle_timer_if.timer tif
);
	logic [31:0] count;
	logic [31:0] next_count;
	logic done;
	logic next_done;

	// A restart with load L flags expiry L+1 cycles later.
	always_comb
	begin
		next_count = count;
		if (tif.restart)
			next_count = tif.load;
		else if (count != 32'h0)
			next_count = count - 32'h1;
		next_done = !tif.restart && (count == 32'h1);
	end

	always_ff @(posedge sys_clk)
	begin
		if (!nrst)
		begin
			count <= 32'h0;
			done <= 1'b0;
		end
		else
		begin
			count <= next_count;
			done <= next_done;
		end
	end

	assign tif.expired = done;
endmodule : cycle_timer

// file: rtl/reset_window_watchdog.sv
// Reset generation and window watchdog of the supply companion chip.
// Assumes a chip select and a 16-bit word captured by an SPI shifter elsewhere.
`include "rww_map.svh"
`timescale 1ns/100ps
module reset_window_watchdog
#(
	parameter int LONG_OPEN_CYC = `RWW_MS_CYC(`RWW_LONG_OPEN_MS),
	parameter int POR_DELAY_CYC = `RWW_MS_CYC(`RWW_POR_DELAY_MS),
	parameter int SHORT_DELAY_CYC = `RWW_MS_CYC(`RWW_SHORT_DELAY_MS),
	parameter int HALF_BASE_CYC = `RWW_MS_CYC(`RWW_HALF_BASE_MS)
)
(
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic vint_uv,
	input wire logic vcc_low,
	input wire logic vcc_current_high,
	input wire logic spi_csn,
	input wire logic spi_word_full,
	input wire logic [15:0] spi_word,
	output logic reset_n_out,
	output logic low_side_switch_one,
	output logic low_side_switch_two,
	output rww_pkg::mode_t mode,
	output logic internal_supply_fail_bit,
	output logic wd_reset_flag,
	output logic wd_running,
	output logic wd_window_open
);
	localparam logic [15:0] FILTER_CYC = 16'(`RWW_FILTER_CYC);

	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!nrst || vint_uv);

	// The half period doubles with each step of the period field.
	function automatic logic [31:0] half_cycles(input logic [2:0] sel);
		half_cycles = 32'(HALF_BASE_CYC) << sel;
	endfunction : half_cycles

	cycle_timer_if tif ();

	cycle_timer u_timer
	(
		.sys_clk(sys_clk),
		.nrst(nrst),
		.tif(tif)
	);

	logic csn_prev;
	logic acc_done;
	logic wd_trig;
	logic wd_fail;
	logic clear_all;
	logic [2:0] period_sel;
	logic short_delay;
	logic stay_on;
	logic ls_one_cfg;
	logic ls_two_cfg;
	logic [2:0] next_period_sel;
	logic next_short_delay;
	logic next_stay_on;
	logic next_ls_one_cfg;
	logic next_ls_two_cfg;
	logic next_supply_ok;
	rww_pkg::mode_t next_mode;
	logic next_flag;
	rww_pkg::rst_state_t rst_state;
	rww_pkg::rst_state_t next_rst_state;
	rww_pkg::wd_state_t wd_state;
	rww_pkg::wd_state_t next_wd_state;
	logic [15:0] filt;
	logic [15:0] next_filt;
	logic next_reset_high;
	logic wd_off_req;

	assign clear_all = vint_uv;
	assign acc_done = spi_csn && !csn_prev && spi_word_full;
	assign wd_trig = acc_done && spi_word[`RWW_WR_BIT];
	// Stop mode only drops the watchdog while the load current is small.
	assign wd_off_req = (mode == rww_pkg::MODE_STOP) && !stay_on
		&& !vcc_current_high;

	always_comb
	begin
		wd_fail = 1'b0;
		unique case (wd_state)
			rww_pkg::WD_LONG, rww_pkg::WD_OPEN:
				wd_fail = tif.expired && !wd_trig;
			rww_pkg::WD_CLOSED:
				wd_fail = wd_trig;
			rww_pkg::WD_HALT, rww_pkg::WD_SUSP:
				wd_fail = 1'b0;
			default:
				wd_fail = 1'b0;
		endcase
	end

	// Reset sequencing owns the timer whenever the reset output is low.
	always_comb
	begin
		next_rst_state = rst_state;
		next_filt = filt;
		tif.restart = 1'b0;
		tif.load = short_delay ? 32'(SHORT_DELAY_CYC - 1)
			: 32'(POR_DELAY_CYC - 1);
		unique case (rst_state)
			rww_pkg::RS_RUN:
			begin
				next_filt = 16'h0;
				if (vcc_low)
					next_rst_state = rww_pkg::RS_FILTER;
			end
			rww_pkg::RS_FILTER:
			begin
				next_filt = filt + 16'h1;
				if (!vcc_low)
					next_rst_state = rww_pkg::RS_RUN;
				else if (filt >= FILTER_CYC - 16'h1)
					next_rst_state = rww_pkg::RS_HOLD;
			end
			rww_pkg::RS_HOLD:
			begin
				if (!vcc_low)
				begin
					next_rst_state = rww_pkg::RS_DELAY;
					tif.restart = 1'b1;
				end
			end
			rww_pkg::RS_DELAY:
			begin
				if (vcc_low)
					next_rst_state = rww_pkg::RS_HOLD;
				else if (tif.expired)
					next_rst_state = rww_pkg::RS_RUN;
			end
		endcase
		if (wd_fail && (rst_state == rww_pkg::RS_RUN
			|| rst_state == rww_pkg::RS_FILTER))
		begin
			next_rst_state = rww_pkg::RS_DELAY;
			tif.restart = 1'b1;
		end
		next_wd_state = wd_state;
		unique case (wd_state)
			rww_pkg::WD_HALT:
				if (next_rst_state == rww_pkg::RS_RUN)
				begin
					next_wd_state = rww_pkg::WD_LONG;
					tif.restart = 1'b1;
					tif.load = 32'(LONG_OPEN_CYC - 1);
				end
			rww_pkg::WD_LONG, rww_pkg::WD_OPEN:
				if (wd_trig)
				begin
					next_wd_state = rww_pkg::WD_CLOSED;
					tif.restart = 1'b1;
					tif.load = half_cycles(next_period_sel) - 32'h1;
				end
			rww_pkg::WD_CLOSED:
				if (tif.expired && !wd_fail)
				begin
					next_wd_state = rww_pkg::WD_OPEN;
					tif.restart = 1'b1;
					tif.load = half_cycles(period_sel) - 32'h1;
				end
			rww_pkg::WD_SUSP:
				if (!wd_off_req)
				begin
					next_wd_state = rww_pkg::WD_LONG;
					tif.restart = 1'b1;
					tif.load = 32'(LONG_OPEN_CYC - 1);
				end
			default:
				next_wd_state = rww_pkg::WD_HALT;
		endcase
		if (wd_state != rww_pkg::WD_HALT && wd_off_req && !wd_fail
			&& next_rst_state == rww_pkg::RS_RUN)
			next_wd_state = rww_pkg::WD_SUSP;
		// A fail or a low reset parks the watchdog until release.
		if (wd_fail || next_rst_state == rww_pkg::RS_HOLD
			|| next_rst_state == rww_pkg::RS_DELAY)
			next_wd_state = rww_pkg::WD_HALT;
	end

	assign next_reset_high = (next_rst_state == rww_pkg::RS_RUN)
		|| (next_rst_state == rww_pkg::RS_FILTER);

	// Settings follow each accepted write; any reset puts mode in standby.
	always_comb
	begin
		next_period_sel = period_sel;
		next_short_delay = short_delay;
		next_stay_on = stay_on;
		next_ls_one_cfg = ls_one_cfg;
		next_ls_two_cfg = ls_two_cfg;
		next_supply_ok = internal_supply_fail_bit;
		next_mode = mode;
		if (wd_trig)
		begin
			next_period_sel = spi_word[`RWW_PER_LSB +: `RWW_PER_W];
			next_short_delay = spi_word[`RWW_SHORT_BIT];
			next_stay_on = spi_word[`RWW_STAY_BIT];
			next_ls_one_cfg = spi_word[`RWW_SW_ONE_BIT];
			next_ls_two_cfg = spi_word[`RWW_SW_TWO_BIT];
			next_mode = rww_pkg::mode_t'(spi_word[`RWW_MODE_LSB +: 2]);
			next_supply_ok = next_supply_ok | spi_word[`RWW_SUPPLY_OK_BIT];
		end
		if (!next_reset_high)
		begin
			next_mode = rww_pkg::MODE_STANDBY;
			next_ls_one_cfg = 1'b0;
			next_ls_two_cfg = 1'b0;
		end
		// Set wins over the clear when both fall in one cycle.
		next_flag = wd_fail || (wd_reset_flag && !acc_done);
	end

	// Internal supply loss wipes all settings, the same as a power-up.
	always_ff @(posedge sys_clk)
	begin
		if (!nrst || clear_all)
		begin
			rst_state <= rww_pkg::RS_HOLD;
			wd_state <= rww_pkg::WD_HALT;
			filt <= 16'h0;
			csn_prev <= 1'b1;
			period_sel <= 3'h0;
			short_delay <= 1'b0;
			stay_on <= 1'b0;
			ls_one_cfg <= 1'b0;
			ls_two_cfg <= 1'b0;
			internal_supply_fail_bit <= 1'b0;
			mode <= rww_pkg::MODE_STANDBY;
			wd_reset_flag <= 1'b0;
			reset_n_out <= 1'b0;
			low_side_switch_one <= 1'b0;
			low_side_switch_two <= 1'b0;
			wd_running <= 1'b0;
			wd_window_open <= 1'b0;
		end
		else
		begin
			rst_state <= next_rst_state;
			wd_state <= next_wd_state;
			filt <= next_filt;
			csn_prev <= spi_csn;
			period_sel <= next_period_sel;
			short_delay <= next_short_delay;
			stay_on <= next_stay_on;
			ls_one_cfg <= next_ls_one_cfg;
			ls_two_cfg <= next_ls_two_cfg;
			internal_supply_fail_bit <= next_supply_ok;
			mode <= next_mode;
			wd_reset_flag <= next_flag;
			reset_n_out <= next_reset_high;
			low_side_switch_one <= next_ls_one_cfg;
			low_side_switch_two <= next_ls_two_cfg;
			wd_running <= next_wd_state != rww_pkg::WD_HALT
				&& next_wd_state != rww_pkg::WD_SUSP;
			wd_window_open <= next_wd_state == rww_pkg::WD_LONG
				|| next_wd_state == rww_pkg::WD_OPEN;
		end
	end

	sequence fail_seen;
		wd_fail;
	endsequence

	sequence reset_drop;
		!reset_n_out ##1 !reset_n_out;
	endsequence

	fail_reset_low_a: assert property (fail_seen |=> reset_drop)
		else $error("watchdog fail did not hold reset low");
	fail_flag_set_a: assert property (fail_seen |=> wd_reset_flag)
		else $error("watchdog fail did not set the flag");
	fail_standby_a: assert property (
		fail_seen |=> mode == rww_pkg::MODE_STANDBY)
		else $error("watchdog fail did not force standby");
	switch_off_a: assert property (
		!reset_n_out |-> !low_side_switch_one && !low_side_switch_two)
		else $error("low-side switch on during reset");
	long_open_a: assert property ($rose(reset_n_out) |->
		wd_state == rww_pkg::WD_LONG && wd_window_open)
		else $error("reset release did not open a long window");
	open_trig_closed_a: assert property (
		wd_trig && wd_state == rww_pkg::WD_OPEN && !wd_off_req
		&& rst_state == rww_pkg::RS_RUN
		|=> wd_state == rww_pkg::WD_CLOSED && !wd_window_open)
		else $error("open window trigger did not close the window");
	closed_trig_fail_a: assert property (
		wd_trig && wd_state == rww_pkg::WD_CLOSED
		|=> !reset_n_out && wd_reset_flag)
		else $error("early trigger was not punished");
	flag_clear_a: assert property (
		acc_done && !wd_fail |=> !wd_reset_flag)
		else $error("access did not clear the watchdog flag");
	stop_off_a: assert property (
		wd_off_req && wd_state != rww_pkg::WD_HALT && reset_n_out
		&& !vcc_low |=> !wd_running)
		else $error("watchdog kept running in stop mode at low current");
	current_on_a: assert property (
		wd_state == rww_pkg::WD_SUSP && vcc_current_high
		&& rst_state == rww_pkg::RS_RUN
		|=> wd_state == rww_pkg::WD_LONG)
		else $error("watchdog not re-enabled on high current");
	filter_low_a: assert property (
		rst_state == rww_pkg::RS_RUN && vcc_low ##1 vcc_low [*2]
		|-> reset_n_out)
		else $error("reset dropped before the filter time");
endmodule : reset_window_watchdog

// file: tb/mcu_model.sv
// Microcontroller side of the control word link, at its pins.
// Assumes the bench calls xfer just after a clock edge.
`timescale 1ns/100ps
module mcu_model
(
	input wire logic sys_clk,
	output logic spi_csn,
	output logic spi_word_full,
	output logic [15:0] spi_word
);
	initial
	begin
		spi_csn = 1'b1;
		spi_word_full = 1'b0;
		spi_word = 16'h5a5a;
	end
	task automatic xfer(input logic [15:0] w, input logic full);
		@(posedge sys_clk);
		spi_csn <= 1'b0;
		spi_word <= w;
		@(posedge sys_clk);
		spi_csn <= 1'b1;
		spi_word_full <= full;
		@(posedge sys_clk);
		// A released word shows its inverse, so stale data is never reused.
		spi_word_full <= 1'b0;
		spi_word <= ~w;
	endtask : xfer
endmodule : mcu_model

// file: tb/test_reset_window_watchdog.sv
// Self-checking bench of the reset and window watchdog block.
// Assumes the small timing parameters below stand for the real counts.
`timescale 1ns/100ps
module test_reset_window_watchdog;
	logic sys_clk = 1'b0;
	logic nrst = 1'b0;
	logic vint_uv = 1'b0;
	logic vcc_low = 1'b0;
	logic cur_hi = 1'b0;
	logic csn, full;
	logic [15:0] word;
	logic rst_o, sw_one, sw_two, fail, flag, run, open;
	rww_pkg::mode_t mode;
	int num_errors = 0;
	int n_tests = 0;
	int cycles = 0;
	int seed = 27575;
	int n, sel, sw;
	always #12.5 sys_clk = ~sys_clk;
	reset_window_watchdog #(.LONG_OPEN_CYC(200), .POR_DELAY_CYC(100),
		.SHORT_DELAY_CYC(20), .HALF_BASE_CYC(16)) DUT (.sys_clk(sys_clk),
		.nrst(nrst), .vint_uv(vint_uv), .vcc_low(vcc_low),
		.vcc_current_high(cur_hi), .spi_csn(csn), .spi_word_full(full),
		.spi_word(word), .reset_n_out(rst_o),
		.low_side_switch_one(sw_one),
		.low_side_switch_two(sw_two), .mode(mode),
		.internal_supply_fail_bit(fail), .wd_reset_flag(flag),
		.wd_running(run), .wd_window_open(open));
	mcu_model mcu (.sys_clk(sys_clk), .spi_csn(csn), .spi_word_full(full),
		.spi_word(word));
	function automatic int xorshift();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >>> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : xorshift
	function automatic logic [15:0] wr(input int s, sh, w, md, kp);
		return 16'h8000 | 16'(s | sh << 3 | kp << 4 | w << 5 | md << 7);
	endfunction : wr
	task automatic stop_test();
		$display("checks %0d errors %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : stop_test
	task automatic chk_bit(input logic got, input logic exp);
		n_tests++;
		if (got !== exp)
		begin
			num_errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk_bit
	task automatic chk_mode(input rww_pkg::mode_t got, input int exp);
		n_tests++;
		if (got !== 2'(exp))
		begin
			num_errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk_mode
	task automatic cyc(input int k);
		repeat (k) @(posedge sys_clk);
		#1;
	endtask : cyc
	task automatic access(input logic [15:0] w, input logic f);
		mcu.xfer(w, f);
		cyc(2);
	endtask : access
	task automatic wait_rise(output int k);
		k = 0;
		while (rst_o !== 1'b1 && k < 500)
		begin
			cyc(1);
			k++;
		end
	endtask : wait_rise
	task automatic safe_state(input int md);
		chk_bit(sw_one, 1'b0);
		chk_bit(sw_two, 1'b0);
		chk_mode(mode, md);
	endtask : safe_state
	always @(posedge sys_clk)
	begin
		cycles++;
		// Whole run needs about 1500 cycles; the ceiling leaves ample room.
		if (cycles == 20000)
		begin
			num_errors++;
			stop_test();
		end
	end
	initial
	begin
		repeat (10) @(posedge sys_clk);
		nrst <= 1'b1;
		wait_rise(n);
		chk_bit(n >= 95 && n <= 110, 1'b1);
		chk_bit(open, 1'b1);
		safe_state(0);
		access(wr(0, 0, 3, 1, 0), 1'b0);
		chk_bit(sw_one, 1'b0);
		sel = 0;
		access(wr(0, 0, 3, 1, 0) | 16'h0200, 1'b1);
		chk_bit(sw_one & sw_two, 1'b1);
		chk_mode(mode, 1);
		repeat (4)
		begin
			cyc((16 << sel) - 3);
			chk_bit(open, 1'b0);
			cyc(6);
			chk_bit(open, 1'b1);
			sel = (xorshift() >> 4) & 1;
			sw = (xorshift() >> 8) & 3;
			access(wr(sel, 1, sw, 1, 0), 1'b1);
			chk_bit(open, 1'b0);
			chk_bit(rst_o, 1'b1);
			chk_bit(sw_one, sw[0]);
			chk_bit(sw_two, sw[1]);
		end
		access(wr(0, 1, 3, 1, 0), 1'b1);
		chk_bit(rst_o, 1'b0);
		chk_bit(flag, 1'b1);
		safe_state(0);
		wait_rise(n);
		chk_bit(n >= 10 && n <= 25, 1'b1);
		chk_bit(open, 1'b1);
		access(16'h0000, 1'b1);
		chk_bit(flag, 1'b0);
		n = 0;
		while (rst_o !== 1'b0 && n < 400)
		begin
			cyc(1);
			n++;
		end
		chk_bit(n >= 185 && n <= 200, 1'b1);
		wait_rise(n);
		access(wr(0, 0, 0, 2, 0), 1'b1);
		chk_bit(run, 1'b0);
		@(posedge sys_clk) cur_hi <= 1'b1;
		cyc(3);
		chk_bit(run & open, 1'b1);
		access(wr(0, 0, 0, 2, 1), 1'b1);
		@(posedge sys_clk) cur_hi <= 1'b0;
		cyc(3);
		chk_bit(run, 1'b1);
		@(posedge sys_clk) vint_uv <= 1'b1;
		cyc(2);
		chk_bit(rst_o | fail | flag | run, 1'b0);
		safe_state(0);
		@(posedge sys_clk) vint_uv <= 1'b0;
		wait_rise(n);
		chk_bit(n >= 95 && n <= 110, 1'b1);
		// Stop mode at low current parks the watchdog, so only supply acts.
		access(wr(0, 0, 1, 2, 0) | 16'h0200, 1'b1);
		chk_bit(fail, 1'b1);
		@(posedge sys_clk) vcc_low <= 1'b1;
		cyc(300);
		chk_bit(rst_o, 1'b1);
		@(posedge sys_clk) vcc_low <= 1'b0;
		cyc(2);
		@(posedge sys_clk) vcc_low <= 1'b1;
		n = 0;
		while (rst_o !== 1'b0 && n < 500)
		begin
			cyc(1);
			n++;
		end
		chk_bit(n >= 395 && n <= 410, 1'b1);
		safe_state(0);
		@(posedge sys_clk) vcc_low <= 1'b0;
		wait_rise(n);
		chk_bit(n >= 95 && n <= 110, 1'b1);
		stop_test();
	end
endmodule : test_reset_window_watchdog
